// *** shared/csh_pkg.sv ***
// Behaviour
// - device read and write strobes change only on device clock rising edges.
// - processor read and write strobes are ANDed, qualified by the decoded select.
// - the qualified request is also gated by the device done line.
// - first stage samples on falling edge; rising edge makes strobe, split by access type.
// - first stage samples done on falling edges, where done is stable.
// - second stage follows first stage on the next rising edge, driving ready and the watchdog count.
// - device strobes stay low until a rising edge sees the first stage or the processor strobe high.
// - address comparator is enabled only for port accesses, not memory accesses.
// - system address is latched on the falling edge of the address latch strobe.
// - device select is asserted on address match or on dma channel grant.
// - select is gated with the request and taken from the first stage on the rising edge.
// - second decode with address bit one high gives an alternative device reset.
// - ready rests low, goes high while second stage is active.
// - ready is released only when second stage active and address match or grant, or when the watchdog has fired.
// - while done is high the request is held out, adding wait states.
// - the path adds the fewest wait states the synchroniser allows.
// - a count of sixteen device clocks forces ready if done stays high.
package csh_pkg;
	// system and device clock periods in ns
	localparam int SYS_CLK_NS = 10;
	localparam int DEV_CLK_NS = 100;
	// system clocks per device clock half period
	localparam int DIV_HALF_CYC = DEV_CLK_NS / (2 * SYS_CLK_NS);
	localparam int DIV_W = 8;
	// device clocks before ready is forced
	localparam int WDOG_DEV_CYC = 16;
	localparam int WD_W = 8;
	// processor address bus
	localparam int ADDR_W = 20;
	localparam int ADDR_A1 = 1;
	localparam int ADDR_A2 = 2;
	localparam int MATCH_LO = 3;
	// reset levels
	localparam logic STAGE_RST = 1'b1;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic READY_RST = 1'b0;
	localparam logic DEV_CLK_RST = 1'b0;
endpackage

// *** verilog/csh_strobe_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module csh_strobe_sync #(
	parameter int DIV_HALF = csh_pkg::DIV_HALF_CYC,
	parameter int WDOG_CYC = csh_pkg::WDOG_DEV_CYC,
	parameter int ADDR_W = csh_pkg::ADDR_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	input wire logic cpu_mem_io,
	input wire logic cpu_ale,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic [ADDR_W-1:0] port_base,
	input wire logic dma_grant_n,
	input wire logic dev_done_n,
	output logic dev_clk,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	output logic dev_cs_n,
	output logic reset_decode_out,
	output logic cpu_ready
);
	typedef struct packed {
		logic [csh_pkg::DIV_W-1:0] div_cnt;
		logic dev_clk;
		logic ale_q;
		logic [ADDR_W-1:0] addr_lat;
		logic first_sync_stage;
		logic second_sync_stage;
		logic rd_n;
		logic wr_n;
		logic cs_n;
		logic rst_dec_n;
		logic ready;
		logic [csh_pkg::WD_W-1:0] wd_cnt;
		logic wd_fire;
	} csh_state_t;

	csh_state_t r;
	csh_state_t next_r;

	logic fall_en;
	logic rise_en;
	logic access_n;
	logic addr_eq;
	logic comp_en;
	logic match_out_primary;
	logic sel_n;
	logic first_stage_input;
	logic last_half;

	// divider edge enables: dev_clk is toggled on the cycle the enable is high
	assign last_half = (r.div_cnt == csh_pkg::DIV_W'(DIV_HALF - 1));
	assign rise_en = last_half && !r.dev_clk;
	assign fall_en = last_half && r.dev_clk;

	// one active-low access request from both processor strobes
	assign access_n = cpu_rd_n & cpu_wr_n;
	// comparator only looks at port cycles, so memory at the same address is ignored
	assign comp_en = !cpu_mem_io && !access_n;
	assign addr_eq = (r.addr_lat[ADDR_W-1:csh_pkg::MATCH_LO]
		== port_base[ADDR_W-1:csh_pkg::MATCH_LO]);
	assign match_out_primary = comp_en && addr_eq && !r.addr_lat[csh_pkg::ADDR_A1]
		&& !r.addr_lat[csh_pkg::ADDR_A2];
	assign sel_n = !(match_out_primary || !dma_grant_n);
	// request qualified by select and held out while the device is busy
	assign first_stage_input = access_n | sel_n | dev_done_n;

	// next-state logic for the whole block
	always_comb begin
		next_r = r;
		// free-running device clock divider
		if (last_half) begin
			next_r.div_cnt = '0;
			next_r.dev_clk = !r.dev_clk;
		end else begin
			next_r.div_cnt = r.div_cnt + csh_pkg::DIV_W'(1);
		end
		// address captured on the falling edge of the latch strobe
		next_r.ale_q = cpu_ale;
		if (r.ale_q && !cpu_ale) begin
			next_r.addr_lat = cpu_addr;
		end
		// first stage samples on the falling edge, when done is already settled
		if (fall_en) begin
			next_r.first_sync_stage = first_stage_input;
		end
		// second stage, strobes and device select change only on the rising edge
		if (rise_en) begin
			next_r.second_sync_stage = r.first_sync_stage;
			// strobe lasts from first-stage low until done has pushed it high or the processor strobe ends
			next_r.rd_n = r.first_sync_stage | cpu_rd_n;
			next_r.wr_n = r.first_sync_stage | cpu_wr_n;
			next_r.cs_n = r.first_sync_stage;
		end
		// alternate reset decode, A1 high on a valid port address
		next_r.rst_dec_n = !(comp_en && addr_eq && r.addr_lat[csh_pkg::ADDR_A1]);
		// watchdog counts device clocks while a selected request waits on busy done
		if (access_n || sel_n) begin
			next_r.wd_cnt = '0;
			next_r.wd_fire = 1'b0;
		end else if (rise_en && dev_done_n && r.second_sync_stage && !r.wd_fire) begin
			if (r.wd_cnt == csh_pkg::WD_W'(WDOG_CYC - 1)) begin
				next_r.wd_fire = 1'b1;
			end else begin
				next_r.wd_cnt = r.wd_cnt + csh_pkg::WD_W'(1);
			end
		end
		// ready released as soon as the strobe is on the device, no extra waits
		next_r.ready = (!next_r.second_sync_stage && !sel_n) || next_r.wd_fire;
	end

	// single register bank; stages reset high so nothing strobes the device
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r.div_cnt <= '0;
			r.dev_clk <= csh_pkg::DEV_CLK_RST;
			r.ale_q <= 1'b0;
			r.addr_lat <= '0;
			r.first_sync_stage <= csh_pkg::STAGE_RST;
			r.second_sync_stage <= csh_pkg::STAGE_RST;
			r.rd_n <= csh_pkg::STROBE_IDLE;
			r.wr_n <= csh_pkg::STROBE_IDLE;
			r.cs_n <= csh_pkg::STROBE_IDLE;
			r.rst_dec_n <= csh_pkg::STROBE_IDLE;
			r.ready <= csh_pkg::READY_RST;
			r.wd_cnt <= '0;
			r.wd_fire <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// device done release and drive-high are the device's part; we only sample it
	assign dev_clk = r.dev_clk;
	assign rd_strobe_n = r.rd_n;
	assign wr_strobe_n = r.wr_n;
	assign dev_cs_n = r.cs_n;
	assign reset_decode_out = r.rst_dec_n;
	assign cpu_ready = r.ready;
endmodule
`default_nettype wire

// *** testbench/csh_sync_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module csh_sync_assertions (
	input wire logic clk_sys, resetn, cpu_rd_n, dev_done_n, dev_clk,
	input wire logic rd_strobe_n, wr_strobe_n, dev_cs_n, cpu_ready);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_two_low; !rd_strobe_n [*8] ##1 rd_strobe_n; endsequence
	property p_edge; $fell(rd_strobe_n) || $fell(wr_strobe_n) |-> $rose(dev_clk); endproperty
	a_edge: assert property (p_edge) else $error("strobe off clock rise");
	property p_width; $fell(rd_strobe_n) |-> s_two_low; endproperty
	a_width: assert property (p_width) else $error("strobe width");
	property p_excl; rd_strobe_n || wr_strobe_n; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_cs; !rd_strobe_n || !wr_strobe_n |-> !dev_cs_n; endproperty
	a_cs: assert property (p_cs) else $error("select not low");
	property p_rdy; $fell(wr_strobe_n) |-> cpu_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_end; $rose(dev_cs_n) |-> rd_strobe_n && wr_strobe_n; endproperty
	a_end: assert property (p_end) else $error("select end");
	property p_src; $fell(rd_strobe_n) |-> !cpu_rd_n; endproperty
	a_src: assert property (p_src) else $error("read source");
	property p_done; $fell(rd_strobe_n) |-> !$past(dev_done_n, 2); endproperty
	a_done: assert property (p_done) else $error("done ignored");
endmodule
`default_nettype wire

// *** testbench/csh_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module csh_dev_model (
	input wire logic dev_clk, rd_strobe_n, wr_strobe_n, input wire logic [7:0] busy,
	output wire logic dev_done_n);
	logic [7:0] cnt = 8'h00;
	assign dev_done_n = cnt != 8'h00;
	// done is driven busy from the fall that sees a strobe, counts down on each rise, then drops
	// one process for both edges, so the busy counter has a single driver
	always @(posedge dev_clk or negedge dev_clk) begin
		if (!dev_clk && !(rd_strobe_n && wr_strobe_n)) cnt <= busy + 8'h02;
		else if (dev_clk && cnt != 8'h00) cnt <= cnt - 8'h01;
	end
endmodule
`default_nettype wire

// *** testbench/cam_host_strobe_sync_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module cam_host_strobe_sync_test;
	logic clk_sys = 1'h0, resetn = 1'h0, cpu_rd_n = 1'h1, cpu_wr_n = 1'h1, cpu_mem_io = 1'h0;
	logic cpu_ale = 1'h0, dma_grant_n = 1'h1;
	logic dev_clk, rd_strobe_n, wr_strobe_n, dev_cs_n, reset_decode_out, cpu_ready, dev_done_n;
	logic [csh_pkg::ADDR_W-1:0] cpu_addr = 20'h00000, port_base = 20'h00348;
	logic [7:0] busy = 8'h01;
	logic [3:0] seen = 4'h0;
	int error_cnt = 0, checks = 0;
	initial forever #5 clk_sys = ~clk_sys;
	csh_strobe_sync #(.DIV_HALF(2), .WDOG_CYC(4)) dut (.*);
	csh_dev_model dev (.*);
	// sticky record, so a short pulse between our sample points is not missed
	always @(posedge clk_sys) seen <= seen | {~rd_strobe_n, ~wr_strobe_n, cpu_ready, ~reset_decode_out};
	task automatic chk(string n, logic [3:0] e, logic [3:0] g);
		checks++;
		error_cnt += int'(e !== g);
		if (e !== g) $display("ERROR %s expected %h seen %h", n, e, g);
	endtask
	task automatic acc(logic wr, mem, dma, go, logic [csh_pkg::ADDR_W-1:0] a, logic [7:0] b);
		logic m, sel;
		busy = b;
		m = !mem && a[19:3] == port_base[19:3];
		sel = dma | m & (a[2:1] == 2'h0);
		@(negedge clk_sys) {cpu_ale, cpu_addr, cpu_mem_io, dma_grant_n} = {1'h1, a, mem, !dma};
		// the address is latched on the edge after ale falls, so the strobe waits one cycle
		@(negedge clk_sys) cpu_ale = 1'h0;
		@(negedge clk_sys) {cpu_rd_n, cpu_wr_n, seen} = {wr, !wr, 4'h0};
		for (int i = 0; i < 60 && cpu_ready !== 1'h1; i++) @(negedge clk_sys);
		// one more edge so the sticky record has taken the ready level too
		@(negedge clk_sys);
		chk("strobes", {go & sel & !wr, go & sel & wr, sel, m & a[1]}, seen);
		@(negedge clk_sys) {cpu_rd_n, cpu_wr_n, dma_grant_n} = 3'h7;
		repeat (30) @(negedge clk_sys);
		$display("access at %h done", a);
	endtask
	initial begin
		void'($urandom(32'hc3e4e70c));
		repeat (16) @(negedge clk_sys);
		resetn = 1'h1;
		for (int i = 0; i < 30; i++) acc(1'($urandom), 1'($urandom % 4 == 0), 1'($urandom % 5 == 0), 1'h1, port_base ^ 20'($urandom % 16), 8'($urandom % 4));
		acc(1'h0, 1'h0, 1'h0, 1'h1, port_base, 8'hc8);
		acc(1'h1, 1'h0, 1'h0, 1'h0, port_base, 8'hc8);
		final_report(0);
	end
	initial #100000 final_report(1);
	task automatic final_report(int late);
		error_cnt += late;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
endmodule
bind csh_strobe_sync csh_sync_assertions chk_i (.*);
`default_nettype wire
